/* hdl/halt_mode_control.sv */
// Purpose: Halt state control between CPU core and interrupt controller.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes:   CPU clock, prefetch and bus cycles are gated; oscillators and peripheral clock stay on.
`timescale 1ns/1ns
`default_nettype none
`include "hmc_defines.svh"

module halt_mode_control #(
    parameter int PRIO_W = `HMC_PRIO_W
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic SRST_I,
    // CPU core
    input wire logic HALT_EXEC_I,
    input wire logic CPU_ON_MAIN_I,
    input wire logic PREFETCH_FULL_I,
    // Interrupt controller
    input wire logic NMI_REQ_I,
    input wire logic MASKABLE_REQ_I,
    input wire logic [PRIO_W-1:0] REQ_PRIO_I,
    input wire logic IN_SERVICE_I,
    input wire logic [PRIO_W-1:0] SERVICE_PRIO_I,
    // Peripheral configuration
    input wire logic SUBCLK_PRESENT_I,
    input wire logic WATCH_ON_MAIN_I,
    input wire logic WDT_INTERVAL_MODE_I,
    // Bus controller side
    input wire logic EXT_MODE_I,
    input wire logic HOLD_REQ_I,
    input wire logic BUS_HOLD_ACK_N_I,
    input wire hmc_pkg::bus_pins_s BUS_PINS_I,
    input wire hmc_pkg::bus_oe_n_s BUS_OE_N_I,
    // Clock gating and status
    output logic CPU_CLK_EN_O,
    output logic PREFETCH_EN_O,
    output logic HALTED_O,
    output logic MAIN_OSC_EN_O,
    output logic SUB_OSC_EN_O,
    output logic PERIPH_CLK_EN_O,
    output logic WATCH_RUN_O,
    output logic WDT_RUN_O,
    output logic WDT_AS_WATCHDOG_O,
    // To interrupt controller and CPU
    output logic INT_ACK_O,
    output logic RESUME_NEXT_O,
    // Bus
    output logic BUS_CYCLE_EN_O,
    output logic BUS_HOLD_ACK_N_O,
    output hmc_pkg::bus_pins_s PINS_O,
    output hmc_pkg::bus_oe_n_s PINS_OE_N_O
);
    import hmc_pkg::*;

    // ======================================================
    // Declarations
    halt_state_e state_r;
    halt_state_e state_nxt;
    logic wake;
    logic higher_prio;
    logic take_ack;
    logic halt_settled;
    logic halting;

    // ======================================================
    // Wake decode
    // A smaller priority code means a more urgent request.
    assign higher_prio = NMI_REQ_I || (REQ_PRIO_I < SERVICE_PRIO_I);

    // Any priority wakes; priority only decides the acknowledge
    assign wake = NMI_REQ_I || MASKABLE_REQ_I;

    // Outside a handler every waking request is taken normally.
    // Inside one, only a more urgent request is acknowledged.
    assign take_ack = !IN_SERVICE_I || higher_prio;

    assign halting = (state_r != ST_RUN);

    // Pins only park once the prefetch queue is full
    assign halt_settled = (state_r == ST_HALT);

    // ======================================================
    // State machine
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RUN: begin
                // Halt is refused while the CPU runs on the subclock
                if (HALT_EXEC_I && CPU_ON_MAIN_I) begin
                    state_nxt = ST_FILL;
                end
            end
            ST_FILL: begin
                if (wake) begin
                    state_nxt = ST_RUN;
                end else if (PREFETCH_FULL_I) begin
                    state_nxt = ST_HALT;
                end
            end
            ST_HALT: begin
                if (wake) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // Reset takes the plain reset path, whatever the state
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ======================================================
    // CPU clock gate and prefetch
    // Gating the clock is what keeps CPU registers intact; nothing
    // in the core is reset or reloaded on entry or exit.
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            CPU_CLK_EN_O <= `HMC_ON;
            PREFETCH_EN_O <= `HMC_ON;
            HALTED_O <= `HMC_OFF;
        end else begin
            CPU_CLK_EN_O <= (state_nxt == ST_RUN);
            PREFETCH_EN_O <= (state_nxt != ST_HALT);
            HALTED_O <= (state_nxt != ST_RUN);
        end
    end

    // ======================================================
    // Exit reporting
    // Only one of the two pulses is given per exit; the request
    // that is not acknowledged stays pending at the controller.
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            INT_ACK_O <= `HMC_OFF;
            RESUME_NEXT_O <= `HMC_OFF;
        end else begin
            INT_ACK_O <= halting && wake && take_ack;
            RESUME_NEXT_O <= halting && wake && !take_ack;
        end
    end

    // ======================================================
    // Oscillators and peripherals
    // These never depend on the halt state.
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            MAIN_OSC_EN_O <= `HMC_ON;
            SUB_OSC_EN_O <= `HMC_ON;
            PERIPH_CLK_EN_O <= `HMC_ON;
        end else begin
            MAIN_OSC_EN_O <= `HMC_ON;
            SUB_OSC_EN_O <= `HMC_ON;
            PERIPH_CLK_EN_O <= `HMC_ON;
        end
    end

    // ======================================================
    // Watch timer and watchdog
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            WATCH_RUN_O <= `HMC_ON;
            WDT_RUN_O <= `HMC_ON;
            WDT_AS_WATCHDOG_O <= `HMC_OFF;
        end else if (state_nxt != ST_RUN) begin
            WATCH_RUN_O <= SUBCLK_PRESENT_I || WATCH_ON_MAIN_I;
            WDT_RUN_O <= WDT_INTERVAL_MODE_I;
            WDT_AS_WATCHDOG_O <= `HMC_OFF;
        end else begin
            WATCH_RUN_O <= `HMC_ON;
            WDT_RUN_O <= `HMC_ON;
            WDT_AS_WATCHDOG_O <= !WDT_INTERVAL_MODE_I;
        end
    end

    // ======================================================
    // Bus cycles and hold
    // While parked the hold acknowledge is generated here so that
    // an external master can still take the bus.
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            BUS_CYCLE_EN_O <= `HMC_ON;
            BUS_HOLD_ACK_N_O <= `HMC_ACK_N_IDLE;
        end else if (state_nxt == ST_HALT) begin
            BUS_CYCLE_EN_O <= `HMC_OFF;
            BUS_HOLD_ACK_N_O <= !HOLD_REQ_I;
        end else begin
            BUS_CYCLE_EN_O <= `HMC_ON;
            BUS_HOLD_ACK_N_O <= BUS_HOLD_ACK_N_I;
        end
    end

    // ======================================================
    // Pin stage
    halt_pin_stage u_pins (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .halt_settled_i(halt_settled),
        .ext_mode_i(EXT_MODE_I),
        .hold_ack_n_i(BUS_HOLD_ACK_N_O),
        .pins_i(BUS_PINS_I),
        .oe_n_i(BUS_OE_N_I),
        .pins_o(PINS_O),
        .oe_n_o(PINS_OE_N_O)
    );

endmodule : halt_mode_control
`default_nettype wire

/* hdl/halt_pin_stage.sv */
// Purpose: Output stage for the external bus pins under halt.
// Assumes: Bus controller values are synchronous to clk_i.
// Notes:   Holding is done by not reloading the pin registers.
`timescale 1ns/1ns
`default_nettype none
`include "hmc_defines.svh"

module halt_pin_stage (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Controls
    input wire logic halt_settled_i,
    input wire logic ext_mode_i,
    input wire logic hold_ack_n_i,
    // From bus controller
    input wire hmc_pkg::bus_pins_s pins_i,
    input wire hmc_pkg::bus_oe_n_s oe_n_i,
    // To pins
    output hmc_pkg::bus_pins_s pins_o,
    output hmc_pkg::bus_oe_n_s oe_n_o
);
    import hmc_pkg::*;

    logic park;
    logic hold_float;

    assign park = halt_settled_i && ext_mode_i;
    assign hold_float = (hold_ack_n_i == `HMC_OE_N_DRIVE);

    // ======================================================
    // Pin values
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pins_o.muxed_addr_data_bus <= `HMC_AD_RST;
            pins_o.upper_addr_lines <= `HMC_UA_RST;
            pins_o.low_byte_enable <= `HMC_OFF;
            pins_o.high_byte_enable <= `HMC_OFF;
            pins_o.rw <= `HMC_RW_READ;
        end else if (park) begin
            // Address and byte enables keep their last value
            pins_o.rw <= `HMC_RW_READ;
        end else begin
            pins_o <= pins_i;
        end
    end

    // ======================================================
    // Output enables
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            oe_n_o.muxed_addr_data_bus <= `HMC_OE_N_FLOAT;
            oe_n_o.upper_addr_lines <= `HMC_OE_N_FLOAT;
            oe_n_o.byte_enables <= `HMC_OE_N_FLOAT;
            oe_n_o.rw <= `HMC_OE_N_FLOAT;
        end else if (park) begin
            oe_n_o.muxed_addr_data_bus <= `HMC_OE_N_FLOAT;
            oe_n_o.upper_addr_lines <= hold_float;
            oe_n_o.byte_enables <= hold_float;
            oe_n_o.rw <= hold_float;
        end else begin
            oe_n_o <= oe_n_i;
        end
    end

endmodule : halt_pin_stage
`default_nettype wire

/* hdl/hmc_defines.svh */
// Purpose: Named constants for the halt mode controller.
// Assumes: Included by bare name from the package and the modules.
// Notes:   Definitions only.
`ifndef HMC_DEFINES_SVH
`define HMC_DEFINES_SVH

// ==========================================================
// Widths
`define HMC_AD_W 16
`define HMC_UA_W 6
`define HMC_PRIO_W 3

// ==========================================================
// Reset and idle values
`define HMC_OFF 1'b0
`define HMC_ON 1'b1
`define HMC_OE_N_DRIVE 1'b0
`define HMC_OE_N_FLOAT 1'b1
`define HMC_ACK_N_IDLE 1'b1
`define HMC_RW_READ 1'b1
`define HMC_AD_RST 16'h0000
`define HMC_UA_RST 6'h00

`endif

/* hdl/hmc_pkg.sv */
// Purpose: Types shared by the halt mode controller files.
// Assumes: hmc_defines.svh supplies widths.
// Notes:   Pin groups travel as packed structs.
`include "hmc_defines.svh"

package hmc_pkg;

    // ======================================================
    // Controller states
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_FILL = 2'b01,
        ST_HALT = 2'b10
    } halt_state_e;

    // ======================================================
    // External bus pin values
    typedef struct packed {
        logic [`HMC_AD_W-1:0] muxed_addr_data_bus;
        logic [`HMC_UA_W-1:0] upper_addr_lines;
        logic low_byte_enable;
        logic high_byte_enable;
        logic rw;
    } bus_pins_s;

    // Output enables, low while driving
    typedef struct packed {
        logic muxed_addr_data_bus;
        logic upper_addr_lines;
        logic byte_enables;
        logic rw;
    } bus_oe_n_s;

endpackage : hmc_pkg

/* verif/halt_mode_control_sva.sv */
// Purpose: Port-level checks for the halt mode controller.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Bound to every controller instance below.
`timescale 1ns/1ns
`default_nettype none
module halt_mode_control_sva #(
    parameter int PRIO_W = 3
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic SRST_I,
    // Requests
    input wire logic HALT_EXEC_I,
    input wire logic CPU_ON_MAIN_I,
    input wire logic NMI_REQ_I,
    input wire logic MASKABLE_REQ_I,
    input wire logic IN_SERVICE_I,
    input wire logic [PRIO_W-1:0] REQ_PRIO_I,
    input wire logic [PRIO_W-1:0] SERVICE_PRIO_I,
    input wire logic EXT_MODE_I,
    // Watched outputs
    input wire logic CPU_CLK_EN_O,
    input wire logic PREFETCH_EN_O,
    input wire logic HALTED_O,
    input wire logic MAIN_OSC_EN_O,
    input wire logic INT_ACK_O,
    input wire logic RESUME_NEXT_O,
    input wire hmc_pkg::bus_oe_n_s PINS_OE_N_O
);
    import hmc_pkg::*;
    logic wake;
    logic urgent;
    assign wake = NMI_REQ_I || MASKABLE_REQ_I;
    // Equal priority is treated as not more urgent
    assign urgent = NMI_REQ_I || !IN_SERVICE_I || REQ_PRIO_I < SERVICE_PRIO_I;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    // ==========================================================
    // Halt entry and exit
    property p_enter; HALT_EXEC_I && CPU_ON_MAIN_I && !HALTED_O |=> HALTED_O && !CPU_CLK_EN_O; endproperty
    a_enter: assert property (p_enter) else $error("halt entry missed");
    property p_refuse; HALT_EXEC_I && !CPU_ON_MAIN_I && !HALTED_O |=> !HALTED_O; endproperty
    a_refuse: assert property (p_refuse) else $error("halt taken off main clock");
    property p_wake; HALTED_O && wake |=> !HALTED_O && CPU_CLK_EN_O && (INT_ACK_O ^ RESUME_NEXT_O); endproperty
    a_wake: assert property (p_wake) else $error("wake did not end halt");
    property p_ack; HALTED_O && wake && urgent |=> INT_ACK_O && !RESUME_NEXT_O; endproperty
    a_ack: assert property (p_ack) else $error("urgent request not acknowledged");
    property p_pend; HALTED_O && MASKABLE_REQ_I && !urgent |=> RESUME_NEXT_O && !INT_ACK_O; endproperty
    a_pend: assert property (p_pend) else $error("lower request acknowledged");
    property p_pulse; INT_ACK_O || RESUME_NEXT_O |=> !INT_ACK_O && !RESUME_NEXT_O; endproperty
    a_pulse: assert property (p_pulse) else $error("exit pulse too long");
    // ==========================================================
    // Clocks and pins
    property p_osc; $rose(HALTED_O) |-> MAIN_OSC_EN_O ##1 MAIN_OSC_EN_O; endproperty
    a_osc: assert property (p_osc) else $error("oscillator stopped in halt");
    property p_park; HALTED_O && !PREFETCH_EN_O && EXT_MODE_I |=> PINS_OE_N_O.muxed_addr_data_bus; endproperty
    a_park: assert property (p_park) else $error("data bus driven in halt");
endmodule : halt_mode_control_sva
bind halt_mode_control halt_mode_control_sva #(.PRIO_W(PRIO_W)) sva_u (.*);
`default_nettype wire

/* verif/hmc_cpu_model.sv */
// Purpose: CPU core side: prefetch queue filling after a halt.
// Assumes: Queue depth is set by the bench for prompt or slow filling.
// Notes:   Changes only on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module hmc_cpu_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // From controller
    input wire logic halted_i,
    input wire logic prefetch_en_i,
    input wire logic [3:0] depth_i,
    // To controller
    output logic prefetch_full_o
);
    logic [3:0] fetched_r;
    always_ff @(negedge clk_i) begin
        if (srst_i || !halted_i) begin
            fetched_r <= 4'h0;
        end else if (prefetch_en_i && fetched_r != depth_i) begin
            fetched_r <= fetched_r + 4'h1;
        end
    end
    // Stays high a half cycle into run after exit; ignored there
    assign prefetch_full_o = fetched_r == depth_i;
endmodule : hmc_cpu_model
`default_nettype wire

/* verif/tb_halt_mode_control.sv */
// Purpose: Random halt, park and wake trials against a behavioural model.
// Assumes: Inputs change on the falling edge.
// Notes:   Bench signals carry the port names so they connect by name.
`timescale 1ns/1ns
`default_nettype none
module tb_halt_mode_control;
    import hmc_pkg::*;
    logic CLK_I = 0, SRST_I = 1, HALT_EXEC_I = 0, CPU_ON_MAIN_I = 1, NMI_REQ_I = 0;
    logic MASKABLE_REQ_I = 0, IN_SERVICE_I = 0, SUBCLK_PRESENT_I = 0, WATCH_ON_MAIN_I = 0;
    logic WDT_INTERVAL_MODE_I = 0, EXT_MODE_I = 0, HOLD_REQ_I = 0, BUS_HOLD_ACK_N_I = 1;
    logic PREFETCH_FULL_I, CPU_CLK_EN_O, PREFETCH_EN_O, HALTED_O, MAIN_OSC_EN_O, SUB_OSC_EN_O;
    logic PERIPH_CLK_EN_O, WATCH_RUN_O, WDT_RUN_O, WDT_AS_WATCHDOG_O, INT_ACK_O, RESUME_NEXT_O;
    logic BUS_CYCLE_EN_O, BUS_HOLD_ACK_N_O;
    logic [2:0] REQ_PRIO_I = 0, SERVICE_PRIO_I = 0;
    logic [3:0] depth = 0;
    logic [31:0] r;
    bus_pins_s BUS_PINS_I = '0, PINS_O;
    bus_oe_n_s BUS_OE_N_I = '0, PINS_OE_N_O;
    int num_errors = 0, tests_run = 0, cycles = 0, exp_ack, n;
    integer seed = 32'hcdc7;
    halt_mode_control dut_u (.*);
    hmc_cpu_model cpu_u (.clk_i(CLK_I), .srst_i(SRST_I), .halted_i(HALTED_O),
        .prefetch_en_i(PREFETCH_EN_O), .depth_i(depth), .prefetch_full_o(PREFETCH_FULL_I));
    always #5 CLK_I = ~CLK_I;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        $display("mismatches %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // Ceiling well above forty trials of at most eight cycles each
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end
    // ==========================================================
    // One halt: enter, fill, park, then wake or reset
    task automatic trial(input bit by_reset);
        r = $random(seed);
        {SUBCLK_PRESENT_I, WATCH_ON_MAIN_I, WDT_INTERVAL_MODE_I, EXT_MODE_I} = r[3:0];
        {HOLD_REQ_I, BUS_HOLD_ACK_N_I, BUS_OE_N_I} = r[9:4];
        // The queue always needs at least one fetch; an empty depth would read full while running
        depth = {2'b00, r[11:10]} + 4'h1;
        BUS_PINS_I = r[31:7];
        HALT_EXEC_I = 1;
        @(negedge CLK_I);
        HALT_EXEC_I = 0;
        check("enter", {HALTED_O, CPU_CLK_EN_O}, 2'b10);
        n = 0;
        while (PREFETCH_EN_O !== 1'b0 && n < 20) begin
            @(negedge CLK_I);
            n++;
        end
        check("fill", {BUS_CYCLE_EN_O, n == depth}, 2'b01);
        BUS_PINS_I = ~BUS_PINS_I;
        @(negedge CLK_I);
        check("periph", {WATCH_RUN_O, WDT_RUN_O, WDT_AS_WATCHDOG_O, SUB_OSC_EN_O,
            PERIPH_CLK_EN_O, BUS_HOLD_ACK_N_O}, {SUBCLK_PRESENT_I | WATCH_ON_MAIN_I,
            WDT_INTERVAL_MODE_I, 3'b011, !HOLD_REQ_I});
        if (EXT_MODE_I) begin
            check("park", {PINS_OE_N_O, PINS_O.rw, PINS_O.upper_addr_lines}, {1'b1,
                {2{HOLD_REQ_I}}, HOLD_REQ_I, 1'b1, ~BUS_PINS_I.upper_addr_lines});
        end else begin
            check("pins", {PINS_O, PINS_OE_N_O}, {BUS_PINS_I, BUS_OE_N_I});
        end
        if (by_reset) begin
            SRST_I = 1;
            @(negedge CLK_I);
            SRST_I = 0;
            check("reset", {CPU_CLK_EN_O, PREFETCH_EN_O, HALTED_O, WDT_AS_WATCHDOG_O,
                INT_ACK_O, RESUME_NEXT_O, BUS_CYCLE_EN_O, BUS_HOLD_ACK_N_O}, 8'hC3);
        end else begin
            r = $random(seed);
            {NMI_REQ_I, MASKABLE_REQ_I, IN_SERVICE_I, REQ_PRIO_I, SERVICE_PRIO_I} = r[8:0];
            MASKABLE_REQ_I = MASKABLE_REQ_I | !NMI_REQ_I;
            exp_ack = NMI_REQ_I || !IN_SERVICE_I || REQ_PRIO_I < SERVICE_PRIO_I;
            @(negedge CLK_I);
            NMI_REQ_I = 0;
            MASKABLE_REQ_I = 0;
            check("wake", {HALTED_O, CPU_CLK_EN_O, PREFETCH_EN_O, INT_ACK_O, RESUME_NEXT_O},
                {3'b011, exp_ack[0], !exp_ack[0]});
            @(negedge CLK_I);
            check("pulse", {INT_ACK_O, RESUME_NEXT_O, CPU_CLK_EN_O, WATCH_RUN_O, WDT_RUN_O,
                WDT_AS_WATCHDOG_O, BUS_HOLD_ACK_N_O, BUS_CYCLE_EN_O, PINS_OE_N_O},
                {5'b00111, !WDT_INTERVAL_MODE_I, BUS_HOLD_ACK_N_I, 1'b1, BUS_OE_N_I});
        end
    endtask : trial
    initial begin
        repeat (6) @(negedge CLK_I);
        check("reset", {MAIN_OSC_EN_O, CPU_CLK_EN_O, HALTED_O, PINS_OE_N_O}, 7'h6F);
        SRST_I = 0;
        CPU_ON_MAIN_I = 0;
        HALT_EXEC_I = 1;
        @(negedge CLK_I);
        HALT_EXEC_I = 0;
        CPU_ON_MAIN_I = 1;
        check("refused", HALTED_O, 1'b0);
        $display("refusal test done");
        // Wake while the queue is still filling ends the halt at once
        depth = 4'h4;
        HALT_EXEC_I = 1;
        @(negedge CLK_I);
        HALT_EXEC_I = 0;
        NMI_REQ_I = 1;
        @(negedge CLK_I);
        NMI_REQ_I = 0;
        check("fill wake", {HALTED_O, CPU_CLK_EN_O, PREFETCH_EN_O, INT_ACK_O}, 4'h7);
        $display("fill wake test done");
        for (int i = 0; i < 40; i++) begin
            trial(i % 8 == 7);
            $display("trial %0d done", i);
        end
        end_of_test();
    end
endmodule : tb_halt_mode_control
`default_nettype wire
